// >>> maint_params.svh
`ifndef MAINT_PARAMS_SVH
`define MAINT_PARAMS_SVH

`define BDI_OFFSET     24'h00_0060
`define MRI_OFFSET     24'h00_0100
`define BDI_RESET      32'h0000_0000
`define MRI_RESET      32'h0000_0000
`define MRI_TID_LSB    0
`define MRI_TID_MSB    7
`define MRI_PRIO_LSB   8
`define MRI_PRIO_MSB   9
`define MRI_CRF_BIT    10
`define MRI_DEST_LSB   16
`define MRI_DEST_MSB   31
`define HOP_LSB        24
`define HOP_MSB        31
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// >>> maint_pkg.sv
`default_nettype none
package maint_pkg;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_LREQ  = 5'b00010,
        ST_LRSP  = 5'b00100,
        ST_RREQ  = 5'b01000,
        ST_RWAIT = 5'b10000
    } state_e;

    typedef enum logic [2:0] {
        PK_NREAD   = 3'h0,
        PK_NWRITE  = 3'h1,
        PK_NWRITE_R = 3'h2,
        PK_SWRITE  = 3'h3,
        PK_MAINT   = 3'h4,
        PK_OTHER   = 3'h5
    } pkt_kind_e;

endpackage
`default_nettype wire

// >>> inbound_checker.sv
`timescale 1ns/1ps
`default_nettype none
module inbound_checker
    import maint_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      reset_n,
    input  wire logic      in_valid,
    input  wire logic      in_lcsba_hit,
    input  wire pkt_kind_e in_kind,
    input  wire logic      in_size_word,
    input  wire logic      in_is_write,
    output logic           chk_done_ff,
    output logic           chk_error_ff,
    output logic           chk_write_en_ff
);
    logic nxt_done;
    logic nxt_error;
    logic nxt_write_en;
    logic cfg_target;
    logic kind_ok;

    always_comb begin
        cfg_target   = in_valid && (in_lcsba_hit || in_kind == PK_MAINT);
        kind_ok      = in_kind == PK_NREAD || in_kind == PK_NWRITE || in_kind == PK_NWRITE_R;
        nxt_done     = cfg_target;
        nxt_error    = cfg_target && ((in_lcsba_hit && !kind_ok) || !in_size_word);
        nxt_write_en = cfg_target && in_is_write && !nxt_error;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chk_done_ff     <= 1'b0;
            chk_error_ff    <= 1'b0;
            chk_write_en_ff <= 1'b0;
        end else begin
            chk_done_ff     <= nxt_done;
            chk_error_ff    <= nxt_error;
            chk_write_en_ff <= nxt_write_en;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    bad_kind_a: assert property (in_valid && in_lcsba_hit && in_kind == PK_OTHER |=> chk_error_ff)
        else $error("Unsupported base-address hit not errored");
    err_no_write_a: assert property (chk_error_ff |-> !chk_write_en_ff)
        else $error("Errored write still enabled");
    size_err_a: assert property (in_valid && in_kind == PK_MAINT && !in_size_word |=> chk_done_ff && chk_error_ff)
        else $error("Non-word maintenance request not errored");
    cov_chk_err_c: cover property (chk_error_ff);
endmodule // inbound_checker
`default_nettype wire

// >>> maintenance_access_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "maint_params.svh"
module maintenance_access_controller
    import maint_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        maint_rst,
    input  wire logic        maint_awvalid,
    output logic             maint_awready_ff,
    input  wire logic [31:0] maint_awaddr,
    input  wire logic        maint_wvalid,
    output logic             maint_wready_ff,
    input  wire logic [31:0] maint_wdata,
    output logic             maint_bvalid_ff,
    input  wire logic        maint_bready,
    output logic [1:0]       maint_bresp_ff,
    input  wire logic        maint_arvalid,
    output logic             maint_arready_ff,
    input  wire logic [31:0] maint_araddr,
    output logic             maint_rvalid_ff,
    input  wire logic        maint_rready,
    output logic [31:0]      maint_rdata_ff,
    output logic [1:0]       maint_rresp_ff,
    output logic             cfg_awvalid_ff,
    input  wire logic        cfg_awready,
    output logic [23:0]      cfg_addr_ff,
    output logic             cfg_wvalid_ff,
    input  wire logic        cfg_wready,
    output logic [31:0]      cfg_wdata_ff,
    input  wire logic        cfg_bvalid,
    output logic             cfg_bready_ff,
    input  wire logic [1:0]  cfg_bresp,
    output logic             cfg_arvalid_ff,
    input  wire logic        cfg_arready,
    input  wire logic        cfg_rvalid,
    output logic             cfg_rready_ff,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic [1:0]  cfg_rresp,
    output logic             req_valid_ff,
    input  wire logic        req_ready,
    output logic             req_is_write_ff,
    output logic [7:0]       req_hop_ff,
    output logic [15:0]      req_srcid_ff,
    output logic [15:0]      req_destid_ff,
    output logic [1:0]       req_prio_ff,
    output logic             req_crf_ff,
    output logic [7:0]       req_tid_ff,
    output logic [23:0]      req_offset_ff,
    output logic [31:0]      req_data_ff,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_is_write,
    input  wire logic [7:0]  rsp_tid,
    input  wire logic        rsp_error,
    input  wire logic [31:0] rsp_data,
    output logic [31:0]      device_identifier_ff,
    input  wire logic        in_valid,
    input  wire logic        in_lcsba_hit,
    input  wire pkt_kind_e   in_kind,
    input  wire logic        in_size_word,
    input  wire logic        in_is_write,
    output logic             chk_done_ff,
    output logic             chk_error_ff,
    output logic             chk_write_en_ff
);
    if (DATA_W != 32) begin : g_width_check
        $error("DATA_W must be 32");
    end

    typedef struct packed {
        state_e      st;
        logic        aw_have, w_have, ar_have, cur_write;
        logic [31:0] aw_addr, w_data, ar_addr, cur_addr, cur_data, mri;
        logic [7:0]  wr_tid, rd_tid;
        logic        awready, wready, arready, bvalid, rvalid;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
        logic        c_awvalid, c_wvalid, c_arvalid, c_bready, c_rready;
        logic        r_valid;
    } eng_s;

    eng_s cur_ff;
    eng_s nxt;
    logic [23:0] offset;
    logic [7:0]  stored_tid;
    logic        tid_match;

    always_comb begin
        nxt = cur_ff;
        offset = {cur_ff.cur_addr[23:2], 2'b00};
        stored_tid = cur_ff.cur_write ? cur_ff.wr_tid : cur_ff.rd_tid;
        tid_match = rsp_valid && rsp_is_write == cur_ff.cur_write && rsp_tid == stored_tid;
        if (maint_awvalid && cur_ff.awready) begin
            nxt.aw_have = 1'b1;
            nxt.aw_addr = maint_awaddr;
        end
        if (maint_wvalid && cur_ff.wready) begin
            nxt.w_have = 1'b1;
            nxt.w_data = maint_wdata;
        end
        if (maint_arvalid && cur_ff.arready) begin
            nxt.ar_have = 1'b1;
            nxt.ar_addr = maint_araddr;
        end
        if (maint_bready && cur_ff.bvalid) begin
            nxt.bvalid = 1'b0;
        end
        if (maint_rready && cur_ff.rvalid) begin
            nxt.rvalid = 1'b0;
        end
        case (cur_ff.st)
            ST_IDLE: begin
                // Writes win the engine; reads wait at most one transaction
                if (cur_ff.aw_have && cur_ff.w_have && !cur_ff.bvalid) begin
                    nxt.cur_write = 1'b1;
                    nxt.cur_addr = cur_ff.aw_addr;
                    nxt.cur_data = cur_ff.w_data;
                    nxt.st = ST_LREQ;
                end else if (cur_ff.ar_have && !cur_ff.rvalid) begin
                    nxt.cur_write = 1'b0;
                    nxt.cur_addr = cur_ff.ar_addr;
                    nxt.st = ST_LREQ;
                end
                if (nxt.st == ST_LREQ) begin
                    if (nxt.cur_addr[`HOP_MSB:`HOP_LSB] != 8'h00) begin
                        nxt.st = ST_RREQ;
                        nxt.r_valid = 1'b1;
                    end else if ({nxt.cur_addr[23:2], 2'b00} != `BDI_OFFSET
                                 && {nxt.cur_addr[23:2], 2'b00} != `MRI_OFFSET) begin
                        // Own registers never reach the fabric, not even for one cycle
                        nxt.c_awvalid = nxt.cur_write;
                        nxt.c_wvalid = nxt.cur_write;
                        nxt.c_arvalid = !nxt.cur_write;
                    end
                end
            end
            ST_LREQ: begin
                // Own registers are answered here without touching the fabric
                if (offset == `BDI_OFFSET || offset == `MRI_OFFSET) begin
                    nxt.c_awvalid = 1'b0;
                    nxt.c_wvalid = 1'b0;
                    nxt.c_arvalid = 1'b0;
                    nxt.st = ST_IDLE;
                    if (cur_ff.cur_write) begin
                        nxt.aw_have = 1'b0;
                        nxt.w_have = 1'b0;
                        nxt.bvalid = 1'b1;
                        nxt.bresp = `RESP_OKAY;
                        if (offset == `MRI_OFFSET) begin
                            nxt.mri = cur_ff.cur_data;
                        end
                    end else begin
                        nxt.ar_have = 1'b0;
                        nxt.rvalid = 1'b1;
                        nxt.rresp = `RESP_OKAY;
                        nxt.rdata = (offset == `MRI_OFFSET) ? cur_ff.mri : device_identifier_ff;
                    end
                end else begin
                    if (cfg_awready) nxt.c_awvalid = 1'b0;
                    if (cfg_wready) nxt.c_wvalid = 1'b0;
                    if (cfg_arready) nxt.c_arvalid = 1'b0;
                    if (!nxt.c_awvalid && !nxt.c_wvalid && !nxt.c_arvalid) begin
                        nxt.st = ST_LRSP;
                        nxt.c_bready = cur_ff.cur_write;
                        nxt.c_rready = !cur_ff.cur_write;
                    end
                end
            end
            ST_LRSP: begin
                if (cur_ff.cur_write && cfg_bvalid) begin
                    nxt.c_bready = 1'b0;
                    nxt.aw_have = 1'b0;
                    nxt.w_have = 1'b0;
                    nxt.bvalid = 1'b1;
                    nxt.bresp = (cfg_bresp == `RESP_OKAY) ? `RESP_OKAY : `RESP_SLVERR;
                    nxt.st = ST_IDLE;
                end else if (!cur_ff.cur_write && cfg_rvalid) begin
                    nxt.c_rready = 1'b0;
                    nxt.ar_have = 1'b0;
                    nxt.rvalid = 1'b1;
                    nxt.rdata = cfg_rdata;
                    nxt.rresp = (cfg_rresp == `RESP_OKAY) ? `RESP_OKAY : `RESP_SLVERR;
                    nxt.st = ST_IDLE;
                end
            end
            ST_RREQ: begin
                if (req_ready) begin
                    nxt.r_valid = 1'b0;
                    if (cur_ff.cur_write) nxt.wr_tid = req_tid_ff;
                    else nxt.rd_tid = req_tid_ff;
                    nxt.mri[`MRI_TID_MSB:`MRI_TID_LSB] = 8'(req_tid_ff + 8'h01);
                    nxt.st = ST_RWAIT;
                end
            end
            ST_RWAIT: begin
                // Responses with a foreign TID are dropped with no trace
                if (tid_match) begin
                    nxt.st = ST_IDLE;
                    if (cur_ff.cur_write) begin
                        nxt.aw_have = 1'b0;
                        nxt.w_have = 1'b0;
                        nxt.bvalid = 1'b1;
                        nxt.bresp = rsp_error ? `RESP_SLVERR : `RESP_OKAY;
                    end else begin
                        nxt.ar_have = 1'b0;
                        nxt.rvalid = 1'b1;
                        nxt.rdata = rsp_data;
                        nxt.rresp = rsp_error ? `RESP_SLVERR : `RESP_OKAY;
                    end
                end
            end
            default: nxt.st = ST_IDLE;
        endcase
        if (maint_rst) begin
            nxt.st = ST_IDLE;
            nxt.aw_have = 1'b0;
            nxt.w_have = 1'b0;
            nxt.ar_have = 1'b0;
            nxt.bvalid = 1'b0;
            nxt.rvalid = 1'b0;
            nxt.wr_tid = 8'h00;
            nxt.rd_tid = 8'h00;
            nxt.c_awvalid = 1'b0;
            nxt.c_wvalid = 1'b0;
            nxt.c_arvalid = 1'b0;
            nxt.c_bready = 1'b0;
            nxt.c_rready = 1'b0;
            nxt.r_valid = 1'b0;
        end
        // Channel stays closed until the response to its single transaction has been accepted
        nxt.awready = !nxt.aw_have && !nxt.bvalid && !maint_rst;
        nxt.wready = !nxt.w_have && !nxt.bvalid && !maint_rst;
        nxt.arready = !nxt.ar_have && !nxt.rvalid && !maint_rst;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_ff <= '{st: ST_IDLE, mri: `MRI_RESET, default: '0};
            device_identifier_ff <= `BDI_RESET;
        end else begin
            cur_ff <= nxt;
            if (cur_ff.st == ST_LREQ && cur_ff.cur_write && offset == `BDI_OFFSET) begin
                device_identifier_ff <= cur_ff.cur_data;
            end
        end
    end

    always_comb begin
        maint_awready_ff = cur_ff.awready;
        maint_wready_ff  = cur_ff.wready;
        maint_arready_ff = cur_ff.arready;
        maint_bvalid_ff  = cur_ff.bvalid;
        maint_bresp_ff   = cur_ff.bresp;
        maint_rvalid_ff  = cur_ff.rvalid;
        maint_rdata_ff   = cur_ff.rdata;
        maint_rresp_ff   = cur_ff.rresp;
        cfg_awvalid_ff   = cur_ff.c_awvalid;
        cfg_wvalid_ff    = cur_ff.c_wvalid;
        cfg_arvalid_ff   = cur_ff.c_arvalid;
        cfg_bready_ff    = cur_ff.c_bready;
        cfg_rready_ff    = cur_ff.c_rready;
        cfg_addr_ff      = {cur_ff.cur_addr[23:2], 2'b00};
        cfg_wdata_ff     = cur_ff.cur_data;
        req_valid_ff     = cur_ff.r_valid;
        req_is_write_ff  = cur_ff.cur_write;
        req_hop_ff       = 8'(cur_ff.cur_addr[`HOP_MSB:`HOP_LSB] - 8'h01);
        req_srcid_ff     = device_identifier_ff[15:0];
        req_destid_ff    = cur_ff.mri[`MRI_DEST_MSB:`MRI_DEST_LSB];
        req_prio_ff      = cur_ff.mri[`MRI_PRIO_MSB:`MRI_PRIO_LSB];
        req_crf_ff       = cur_ff.mri[`MRI_CRF_BIT];
        req_tid_ff       = cur_ff.mri[`MRI_TID_MSB:`MRI_TID_LSB];
        req_offset_ff    = {cur_ff.cur_addr[23:2], 2'b00};
        req_data_ff      = cur_ff.cur_data;
    end

    inbound_checker u_inbound_checker (
        .clk             (clk),
        .reset_n         (reset_n),
        .in_valid        (in_valid),
        .in_lcsba_hit    (in_lcsba_hit),
        .in_kind         (in_kind),
        .in_size_word    (in_size_word),
        .in_is_write     (in_is_write),
        .chk_done_ff     (chk_done_ff),
        .chk_error_ff    (chk_error_ff),
        .chk_write_en_ff (chk_write_en_ff)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    hop_count_a: assert property (req_valid_ff |-> req_hop_ff == 8'(cur_ff.cur_addr[31:24] - 8'h01))
        else $error("Hop count not upper byte minus one");
    source_id_a: assert property (req_valid_ff |-> req_srcid_ff == device_identifier_ff[15:0])
        else $error("Source ID differs from base identifier");
    tid_step_a: assert property (req_valid_ff && req_ready && !maint_rst |=> req_tid_ff == 8'($past(req_tid_ff) + 8'h01))
        else $error("TID did not increment");
    one_write_a: assert property (maint_bvalid_ff |-> !maint_awready_ff && !maint_wready_ff)
        else $error("Write channel open while response pending");
    drop_foreign_a: assert property (cur_ff.st == ST_RWAIT && rsp_valid && rsp_tid != stored_tid && !maint_rst
        |=> cur_ff.st == ST_RWAIT && !maint_bvalid_ff && !maint_rvalid_ff)
        else $error("Foreign TID response accepted");
    cancel_a: assert property (maint_rst |=> cur_ff.st == ST_IDLE && !req_valid_ff && cur_ff.wr_tid == 8'h00)
        else $error("Port reset did not cancel");
    pair_first_a: assert property (cur_ff.st != ST_IDLE && cur_ff.cur_write |-> cur_ff.aw_have && cur_ff.w_have)
        else $error("Write forwarded without address and data");
    local_only_a: assert property ($rose(cfg_arvalid_ff) || $rose(cfg_awvalid_ff) |-> cur_ff.cur_addr[31:24] == 8'h00)
        else $error("Remote address sent to fabric");
    word_addr_a: assert property (cfg_awvalid_ff || req_valid_ff |-> cfg_addr_ff[1:0] == 2'b00 && req_offset_ff[1:0] == 2'b00)
        else $error("Low address bits passed on");
    local_data_a: assert property (cur_ff.st == ST_LRSP && !cur_ff.cur_write && cfg_rvalid && !maint_rst
        |=> maint_rvalid_ff && maint_rdata_ff == $past(cfg_rdata))
        else $error("Fabric read data not returned");
    remote_data_a: assert property (cur_ff.st == ST_RWAIT && tid_match && !cur_ff.cur_write && !maint_rst
        |=> maint_rvalid_ff && maint_rdata_ff == $past(rsp_data) && maint_rresp_ff == ($past(rsp_error) ? 2'h2 : 2'h0))
        else $error("Remote read result not returned");
    dest_field_a: assert property (req_valid_ff |-> req_destid_ff == cur_ff.mri[31:16] && req_crf_ff == cur_ff.mri[10])
        else $error("Request fields not from info register");
    resp_code_a: assert property (maint_bvalid_ff |-> maint_bresp_ff inside {2'h0, 2'h2})
        else $error("Illegal write response code");

    cov_remote_read_c: cover property (cur_ff.st == ST_RWAIT && tid_match && !cur_ff.cur_write);
    cov_local_write_c: cover property (cur_ff.st == ST_LRSP && cfg_bvalid);
    cov_cancel_c: cover property (cur_ff.st == ST_RWAIT && maint_rst);
endmodule // maintenance_access_controller
`default_nettype wire

// >>> maint_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module maint_far_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        cfg_bready_ff,
    input  wire logic        cfg_rready_ff,
    input  wire logic [23:0] cfg_addr_ff,
    input  wire logic        req_valid_ff,
    input  wire logic        req_is_write_ff,
    input  wire logic [7:0]  req_tid_ff,
    input  wire logic [1:0]  mode,
    output logic             cfg_awready,
    output logic             cfg_wready,
    output logic             cfg_arready,
    output logic             req_ready,
    output logic [1:0]       cfg_bresp,
    output logic [1:0]       cfg_rresp,
    output logic             cfg_bvalid,
    output logic             cfg_rvalid,
    output logic [31:0]      cfg_rdata,
    output logic             rsp_valid,
    output logic             rsp_is_write,
    output logic             rsp_error,
    output logic [7:0]       rsp_tid,
    output logic [31:0]      rsp_data
);
    logic [4:0] cnt;
    logic [7:0] tid;
    assign {cfg_awready, cfg_wready, cfg_arready, req_ready, cfg_bresp, cfg_rresp} = 8'hF0;
    // Idle buses show the inverse, so a stale sample never looks right
    assign cfg_rdata = {8'h5A, cfg_addr_ff} ^ {32{!cfg_rvalid}};
    assign rsp_data = {24'hC0_DE00, rsp_tid} ^ {32{!rsp_valid}};
    // Mode 1 sends a stray errored TID first, 2 answers with error, 3 answers late
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {cnt, tid, cfg_bvalid, cfg_rvalid, rsp_valid, rsp_is_write, rsp_error, rsp_tid} <= 26'h0;
        end else begin
            cfg_bvalid <= cfg_bready_ff && !cfg_bvalid;
            cfg_rvalid <= cfg_rready_ff && !cfg_rvalid;
            rsp_valid <= 1'b0;
            if (req_valid_ff) begin
                cnt <= (mode == 2'h3) ? 5'h14 : 5'h6;
                tid <= req_tid_ff;
                rsp_is_write <= req_is_write_ff;
            end else if (cnt != 5'h0) begin
                cnt <= cnt - 5'h1;
                if (cnt == 5'h1 || (cnt == 5'h4 && mode == 2'h1)) begin
                    rsp_valid <= 1'b1;
                    rsp_tid <= (cnt == 5'h4) ? tid + 8'h1 : tid;
                    rsp_error <= (cnt == 5'h4) || (mode == 2'h2);
                end
            end
        end
    end
endmodule // maint_far_model
`default_nettype wire

// >>> maintenance_access_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
module maintenance_access_controller_bench
    import maint_pkg::*;
;
    logic        clk, reset_n, maint_rst, maint_awvalid, maint_awready_ff, maint_wvalid, maint_wready_ff, seen;
    logic        maint_bvalid_ff, maint_bready, maint_arvalid, maint_arready_ff, maint_rvalid_ff, maint_rready;
    logic        cfg_awvalid_ff, cfg_awready, cfg_wvalid_ff, cfg_wready, cfg_bvalid, cfg_bready_ff, cfg_arvalid_ff;
    logic        cfg_arready, cfg_rvalid, cfg_rready_ff, req_valid_ff, req_ready, req_is_write_ff, req_crf_ff;
    logic        rsp_valid, rsp_is_write, rsp_error, in_valid, in_lcsba_hit, in_size_word, in_is_write;
    logic        chk_done_ff, chk_error_ff, chk_write_en_ff;
    logic [1:0]  maint_bresp_ff, maint_rresp_ff, cfg_bresp, cfg_rresp, req_prio_ff, mode;
    logic [7:0]  req_hop_ff, req_tid_ff, rsp_tid;
    logic [15:0] req_srcid_ff, req_destid_ff;
    logic [23:0] cfg_addr_ff, req_offset_ff;
    logic [31:0] maint_awaddr, maint_wdata, maint_rdata_ff, maint_araddr, cfg_wdata_ff, cfg_rdata;
    logic [31:0] req_data_ff, rsp_data, device_identifier_ff;
    logic [63:0] cap, cw;
    pkt_kind_e   in_kind;
    int          n_errors, n_compared, i;
    maintenance_access_controller maintenance_access_controller_i (.*);
    maint_far_model maint_far_model_i (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Fields are snapshot at the accepting edge, they may move afterwards
    always @(posedge clk) begin
        if (req_valid_ff && req_ready)
            cap = {13'h0, req_hop_ff, req_tid_ff, req_destid_ff, req_prio_ff, req_crf_ff, req_srcid_ff};
        if (cfg_wvalid_ff && cfg_wready)
            cw = {8'h0, cfg_addr_ff, cfg_wdata_ff};
    end
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic guard(input int k);
        if (k > 300) begin
            n_errors++;
            $display("BAD %0t wait ran out", $time);
            summarize();
        end
    endtask
    // Data leads the address by dly cycles
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r, input int dly);
        int k;
        maint_awaddr <= a;
        maint_wdata <= d;
        maint_wvalid <= 1'b1;
        maint_awvalid <= (dly == 0);
        maint_bready <= 1'b1;
        for (k = 0; k == 0 || !maint_bvalid_ff; k++) begin
            @(posedge clk);
            if (maint_wready_ff) maint_wvalid <= 1'b0;
            if (maint_awready_ff && maint_awvalid) maint_awvalid <= 1'b0;
            else if (k + 1 == dly) maint_awvalid <= 1'b1;
            guard(k);
        end
        chk(64'(maint_bresp_ff), 64'(r));
        maint_bready <= 1'b0;
        @(posedge clk);
    endtask
    // With wt low only the address handshake is awaited
    task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r, input bit wt);
        int k;
        bit t;
        t = 1'b0;
        maint_araddr <= a;
        maint_arvalid <= 1'b1;
        maint_rready <= wt;
        for (k = 0; !t || (wt && !maint_rvalid_ff); k++) begin
            @(posedge clk);
            if (maint_arready_ff && !t) begin
                t = 1'b1;
                maint_arvalid <= 1'b0;
            end
            guard(k);
        end
        if (wt) begin
            if (r == 2'h0) chk(64'(maint_rdata_ff), 64'(d));
            chk(64'(maint_rresp_ff), 64'(r));
        end
        maint_rready <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        {maint_rst, maint_awvalid, maint_wvalid, maint_bready, maint_arvalid, maint_rready} = 6'h0;
        {in_valid, in_lcsba_hit, in_size_word, in_is_write, reset_n} = 5'h0;
        {maint_awaddr, maint_wdata, maint_araddr, cw} = 160'h0;
        {n_errors, n_compared, mode, in_kind} = {32'h0, 32'h0, 2'h0, PK_NREAD};
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(64'(device_identifier_ff), 64'h0);
        wr(32'h0000_0063, 32'h0000_00AB, 2'h0, 3);
        chk(64'(device_identifier_ff), 64'hAB);
        rd(32'h0000_0062, 32'h0000_00AB, 2'h0, 1);
        chk(cw, 64'h0);
        wr(32'h0000_0200, 32'h1111_2222, 2'h0, 0);
        chk(cw, 64'h0000_0200_1111_2222);
        rd(32'h0000_0207, 32'h5A00_0204, 2'h0, 1);
        $display("local test done");
        wr(32'h0000_0100, 32'h0123_0705, 2'h0, 0);
        rd(32'h0300_0061, 32'hC0DE_0005, 2'h0, 1);
        chk(cap, {13'h0, 8'h02, 8'h05, 16'h0123, 2'h3, 1'b1, 16'h00AB});
        rd(32'h0000_0100, 32'h0123_0706, 2'h0, 1);
        mode <= 2'h1;
        wr(32'hFF00_0040, 32'h5555_AAAA, 2'h0, 0);
        chk(cap, {13'h0, 8'hFE, 8'h06, 16'h0123, 2'h3, 1'b1, 16'h00AB});
        mode <= 2'h2;
        rd(32'h0200_0000, 32'h0, 2'h2, 1);
        mode <= 2'h3;
        rd(32'h0100_0010, 32'h0, 2'h0, 0);
        maint_rready <= 1'b1;
        repeat (3) @(posedge clk);
        chk(64'(maint_arready_ff), 64'h0);
        maint_rst <= 1'b1;
        @(posedge clk);
        maint_rst <= 1'b0;
        seen = 1'b0;
        repeat (30) begin
            @(posedge clk);
            seen = seen | maint_rvalid_ff;
        end
        chk(64'(seen), 64'h0);
        mode <= 2'h0;
        rd(32'h0000_0100, 32'h0123_0709, 2'h0, 1);
        $display("remote test done");
        for (i = 0; i < 8; i++) begin
            in_kind <= pkt_kind_e'((i == 6) ? 4 : (i == 7) ? 0 : i);
            in_lcsba_hit <= (i != 6);
            in_size_word <= (i < 6);
            in_is_write <= 1'b1;
            in_valid <= 1'b1;
            @(posedge clk);
            in_valid <= 1'b0;
            @(posedge clk);
            chk(64'({chk_done_ff, chk_error_ff, chk_write_en_ff}), {61'h0, 1'b1, i > 2, i < 3});
        end
        $display("inbound test done");
        summarize();
    end
endmodule // maintenance_access_controller_bench
`default_nettype wire
